// file: rtl/ebc_ctrl.sv
// External bus cycle controller: strobes, selects, sizing and termination
`timescale 1ns/100ps
`include "ebc_consts.svh"
module ebc_ctrl #(
  parameter int N_CS = 8,
  parameter int ADDR_W = 24
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic REQ_VALID_I,
  input wire ebc_pkg::ebc_req_s REQ_I,
  output logic REQ_READY_O,
  output ebc_pkg::ebc_rsp_s RSP_O,
  input wire logic [N_CS-1:0][1:0] CS_WIDTH_I,
  input wire logic SDRAM_MODE_I,
  output logic [ADDR_W-1:0] A_O,
  input wire logic [15:0] D_I,
  output logic [15:0] D_O,
  output logic D_OE_O,
  output logic [1:0] BS_O,
  output logic OE_N_O,
  output logic RW_O,
  input wire logic TA_N_I,
  input wire logic TEA_N_I,
  input wire logic [1:0] TSIZ_I,
  output logic [1:0] TSIZ_O,
  output logic TSIZ_OE_O,
  output logic TS_N_O,
  output logic TIP_N_O,
  output logic [N_CS-1:0] CS_N_O,
  output logic [1:0] SDCS_N_O
);
  import ebc_pkg::*;

  // ==========================================
  // Parameter checks
  initial
  begin
    if (N_CS < 4 || N_CS > 8 || ADDR_W < 2 || ADDR_W > 32)
    begin
      $error("ebc_ctrl: unsupported N_CS or ADDR_W");
    end
  end

  // ==========================================
  // State
  ebc_state_e st_q, st_d;
  logic [1:0] beats_q, beats_d;
  logic bb8_q, bb8_d;
  logic byte_q, byte_d;
  logic lane_q, lane_d;
  logic wr_q, wr_d;
  logic [1:0] tgt_q, tgt_d;
  logic [2:0] cs_q, cs_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [31:0] wd_q, wd_d;
  logic [31:0] rd_q, rd_d;
  logic [1:0] boot_w_q;
  logic launch;
  logic [1:0] width;
  // Pin registers
  logic ts_n_q, ts_n_d, tip_n_q, tip_n_d, oe_n_q, oe_n_d, rw_q, rw_d;
  logic [1:0] bs_q, bs_d, lanes, tsiz_q, tsiz_d, sdcs_n_q, sdcs_n_d;
  logic [15:0] do_q, do_d;
  logic doe_q, doe_d, ready_q, ready_d;
  logic [N_CS-1:0] cs_n_q, cs_hit;
  ebc_rsp_s rsp_q, rsp_d;

  // ==========================================
  // Chip select decode
  // One select per device, SDRAM reuse
  for (genvar i = 0; i < N_CS; i++)
  begin : g_cs
    assign cs_hit[i] = (st_d == EBC_BEAT) && (tgt_d == `EBC_TGT_EXT) && (cs_d == 3'(i)) &&
                       !(SDRAM_MODE_I && (i == `EBC_SDCS_LO || i == `EBC_SDCS_HI));
  end

  // ==========================================
  // Next state
  always_comb
  begin
    st_d = st_q;
    beats_d = beats_q;
    bb8_d = bb8_q;
    byte_d = byte_q;
    lane_d = lane_q;
    wr_d = wr_q;
    tgt_d = tgt_q;
    cs_d = cs_q;
    addr_d = addr_q;
    wd_d = wd_q;
    rd_d = rd_q;
    launch = 1'b0;
    rsp_d = rsp_q;
    rsp_d.done = 1'b0;
    rsp_d.err = 1'b0;
    width = (REQ_I.cs == 3'h0) ? boot_w_q : CS_WIDTH_I[REQ_I.cs];
    case (st_q)
      EBC_IDLE:
      begin
        if (REQ_VALID_I && ready_q)
        begin
          wr_d = REQ_I.write;
          tgt_d = REQ_I.target;
          cs_d = REQ_I.cs;
          // Low address bits drive the pins
          addr_d = REQ_I.addr[ADDR_W-1:0];
          lane_d = REQ_I.addr[0];
          byte_d = (REQ_I.size == `EBC_SZ_BYTE);
          // SDRAM is always a 16-bit port
          bb8_d = (width == `EBC_SZ_BYTE) && (REQ_I.target != `EBC_TGT_SDRAM);
          rd_d = 32'h0;
          // Dynamic sizing into 8- or 16-bit beats
          case (REQ_I.size)
            `EBC_SZ_BYTE:
            begin
              beats_d = `EBC_BEATS_1;
              wd_d = {REQ_I.wdata[7:0], 24'h0};
            end
            `EBC_SZ_WORD:
            begin
              beats_d = bb8_d ? `EBC_BEATS_2 : `EBC_BEATS_1;
              wd_d = {REQ_I.wdata[15:0], 16'h0};
            end
            default:
            begin
              beats_d = bb8_d ? `EBC_BEATS_4 : `EBC_BEATS_2;
              wd_d = REQ_I.wdata;
            end
          endcase
          if (REQ_I.target == `EBC_TGT_EXT || REQ_I.target == `EBC_TGT_SDRAM)
          begin
            st_d = EBC_BEAT;
            launch = 1'b1;
          end
          else
          begin
            st_d = EBC_INT;
          end
        end
      end
      EBC_INT:
      begin
        // On-chip targets finish in one internal cycle
        rsp_d.done = 1'b1;
        st_d = EBC_IDLE;
      end
      EBC_BEAT:
      begin
        // Error wins over acknowledge, rest abandoned
        if (!TEA_N_I)
        begin
          rsp_d.done = 1'b1;
          rsp_d.err = 1'b1;
          st_d = EBC_IDLE;
        end
        else if (!TA_N_I)
        begin
          if (!wr_q)
          begin
            if (bb8_q)
            begin
              rd_d = {rd_q[23:0], D_I[15:8]};
            end
            else if (byte_q)
            begin
              rd_d = {24'h0, lane_q ? D_I[7:0] : D_I[15:8]};
            end
            else
            begin
              rd_d = {rd_q[15:0], D_I};
            end
          end
          if (beats_q != `EBC_BEATS_1)
          begin
            beats_d = beats_q - 2'h1;
            addr_d = addr_q + ADDR_W'(bb8_q ? `EBC_STEP_8 : `EBC_STEP_16);
            wd_d = bb8_q ? {wd_q[23:0], 8'h0} : {wd_q[15:0], 16'h0};
            launch = 1'b1;
          end
          else
          begin
            rsp_d.done = 1'b1;
            st_d = EBC_IDLE;
          end
        end
      end
      default:
      begin
        st_d = EBC_IDLE;
      end
    endcase
    rsp_d.rdata = rd_d;
  end

  // ==========================================
  // Pin values
  always_comb
  begin
    ready_d = (st_d == EBC_IDLE);
    // Start low only in a launch cycle
    ts_n_d = !launch;
    tip_n_d = (st_d != EBC_BEAT);
    // External drive allowed on reads only
    oe_n_d = !((st_d == EBC_BEAT) && !wr_d);
    // High read, low write, SDRAM alike
    rw_d = (st_d == EBC_BEAT) ? !wr_d : 1'b1;
    // Upper lane holds the lower address byte
    if (bb8_d)
    begin
      lanes = `EBC_LANE_UP;
    end
    else if (byte_d)
    begin
      lanes = lane_d ? `EBC_LANE_LOW : `EBC_LANE_UP;
    end
    else
    begin
      lanes = `EBC_LANE_BOTH;
    end
    // Peripheral strobes yes, on-chip SRAM none
    if ((st_d == EBC_BEAT) || (st_d == EBC_INT && tgt_d == `EBC_TGT_PERIPH))
    begin
      bs_d = (tgt_d == `EBC_TGT_SDRAM) ? lanes : ~lanes;
    end
    else
    begin
      bs_d = `EBC_LANE_IDLE;
    end
    // Write data on the 16 lines
    doe_d = (st_d == EBC_BEAT) && wr_d;
    do_d = (bb8_d || byte_d) ? {wd_d[31:24], wd_d[31:24]} : wd_d[31:16];
    tsiz_d = (st_d == EBC_BEAT) ? ((bb8_d || byte_d) ? `EBC_SZ_BYTE : `EBC_SZ_WORD) : tsiz_q;
    // SDRAM selects follow the low select bit
    sdcs_n_d = 2'h3;
    if ((st_d == EBC_BEAT) && (tgt_d == `EBC_TGT_SDRAM))
    begin
      sdcs_n_d[cs_d[0]] = 1'b0;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      st_q <= EBC_IDLE;
      beats_q <= `EBC_BEATS_1;
      bb8_q <= 1'b0;
      byte_q <= 1'b0;
      lane_q <= 1'b0;
      wr_q <= 1'b0;
      tgt_q <= `EBC_TGT_EXT;
      cs_q <= 3'h0;
      addr_q <= '0;
      wd_q <= 32'h0;
      rd_q <= 32'h0;
      // Size pins read as strap while in reset
      boot_w_q <= TSIZ_I;
      ts_n_q <= 1'b1;
      tip_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      rw_q <= 1'b1;
      bs_q <= `EBC_LANE_IDLE;
      tsiz_q <= `EBC_SZ_LONG;
      sdcs_n_q <= 2'h3;
      do_q <= 16'h0;
      doe_q <= 1'b0;
      ready_q <= 1'b0;
      cs_n_q <= '1;
      rsp_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      beats_q <= beats_d;
      bb8_q <= bb8_d;
      byte_q <= byte_d;
      lane_q <= lane_d;
      wr_q <= wr_d;
      tgt_q <= tgt_d;
      cs_q <= cs_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      ts_n_q <= ts_n_d;
      tip_n_q <= tip_n_d;
      oe_n_q <= oe_n_d;
      rw_q <= rw_d;
      bs_q <= bs_d;
      tsiz_q <= tsiz_d;
      sdcs_n_q <= sdcs_n_d;
      do_q <= do_d;
      doe_q <= doe_d;
      ready_q <= ready_d;
      cs_n_q <= ~cs_hit;
      rsp_q <= rsp_d;
    end
  end

  // Size pins float in reset so the strap can be read
  logic tsiz_oe_q;
  always_ff @(posedge CORE_CLK_I)
  begin
    tsiz_oe_q <= RESET_N_I;
  end

  assign REQ_READY_O = ready_q;
  assign RSP_O = rsp_q;
  assign A_O = addr_q;
  assign D_O = do_q;
  assign D_OE_O = doe_q;
  assign BS_O = bs_q;
  assign OE_N_O = oe_n_q;
  assign RW_O = rw_q;
  assign TSIZ_O = tsiz_q;
  assign TSIZ_OE_O = tsiz_oe_q;
  assign TS_N_O = ts_n_q;
  assign TIP_N_O = tip_n_q;
  assign CS_N_O = cs_n_q;
  assign SDCS_N_O = sdcs_n_q;

  // ==========================================
  // Assertions
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_wait;
    TA_N_I && TEA_N_I;
  endsequence
  sequence s_open;
    !TIP_N_O ##0 s_wait;
  endsequence

  AST_TS_SINGLE: assert property (!TS_N_O ##0 s_wait |=> TS_N_O)
    else $error("transfer start held past one clock");
  AST_TS_IN_TIP: assert property (!TS_N_O |-> !TIP_N_O)
    else $error("transfer start outside transfer");
  AST_OE_READ: assert property (!OE_N_O |-> RW_O && !TIP_N_O && !D_OE_O)
    else $error("output enable outside a read");
  AST_RW_WRITE: assert property (D_OE_O |-> !RW_O && OE_N_O)
    else $error("data driven while direction is read");
  AST_HOLD: assert property (s_open |=> !TIP_N_O && $stable(A_O) && $stable(CS_N_O) && $stable(BS_O))
    else $error("bus cycle changed before termination");
  AST_TEA_END: assert property (!TIP_N_O && !TEA_N_I |=> TIP_N_O && RSP_O.err && RSP_O.done)
    else $error("error acknowledge did not end cycle");
  AST_ACK_END: assert property (RSP_O.done && !RSP_O.err && $past(!TIP_N_O) |-> $past(!TA_N_I) && TIP_N_O)
    else $error("cycle ended without acknowledge");
  AST_CS_ONE: assert property ($onehot0(~CS_N_O) && !(!TIP_N_O && TS_N_O && $rose(&CS_N_O)))
    else $error("chip select fault");
  AST_BS_IDLE: assert property (TIP_N_O && st_q != EBC_INT |-> BS_O == `EBC_LANE_IDLE)
    else $error("byte strobe active outside access");
  AST_BOOT: assert property ($rose(RESET_N_I) |-> boot_w_q == $past(TSIZ_I))
    else $error("boot width not taken from size pins");
endmodule

// file: rtl/ebc_consts.svh
// Encodings and constants of the external bus cycle controller
`ifndef EBC_CONSTS_SVH
`define EBC_CONSTS_SVH
// Access sizes, port widths and transfer-size pin codes share one encoding
`define EBC_SZ_LONG 2'h0
`define EBC_SZ_BYTE 2'h1
`define EBC_SZ_WORD 2'h2
// Request targets
`define EBC_TGT_EXT 2'h0
`define EBC_TGT_PERIPH 2'h1
`define EBC_TGT_ONCHIP 2'h2
`define EBC_TGT_SDRAM 2'h3
// Active byte lanes, upper lane in bit 1
`define EBC_LANE_BOTH 2'h3
`define EBC_LANE_UP 2'h2
`define EBC_LANE_LOW 2'h1
`define EBC_LANE_IDLE 2'h3
// Remaining beat counts after the first beat
`define EBC_BEATS_1 2'h0
`define EBC_BEATS_2 2'h1
`define EBC_BEATS_4 2'h3
// Address steps per beat
`define EBC_STEP_8 24'h000001
`define EBC_STEP_16 24'h000002
// Chip select indices shared with the SDRAM selects
`define EBC_SDCS_LO 2
`define EBC_SDCS_HI 3
`endif

// file: rtl/ebc_pkg.sv
// Types of the external bus cycle controller
package ebc_pkg;
  typedef enum logic [1:0] {EBC_IDLE = 2'b00, EBC_BEAT = 2'b01, EBC_INT = 2'b10} ebc_state_e;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic [1:0] size;
    logic [1:0] target;
    logic [2:0] cs;
  } ebc_req_s;
  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } ebc_rsp_s;
endpackage

// file: bench/ebc_mem_model.sv
// Behavioural external memory behind the bus controller
`timescale 1ns/100ps
module ebc_mem_model (
  input wire logic clk_i,
  input wire logic [23:0] a_i,
  input wire logic [15:0] d_i,
  input wire logic [1:0] lane_n_i,
  input wire logic oe_n_i,
  input wire logic rw_i,
  input wire logic busy_n_i,
  input wire logic [3:0] wait_i,
  input wire logic fail_i,
  output logic [15:0] d_o,
  output logic ack_n_o,
  output logic err_n_o
);
  logic [7:0] mem [256];
  logic [3:0] cnt_q = 4'h0;
  logic [15:0] old_q = 16'h0;
  logic hit;
  logic [7:0] ev;
  // ========================================
  // Answer
  assign hit = !busy_n_i && cnt_q == wait_i;
  assign ack_n_o = !(hit && !fail_i);
  assign err_n_o = !(hit && fail_i);
  assign ev = {a_i[7:1], 1'b0};
  // memory data driven only when enabled
  // Released bus toggles so stale data never passes
  assign d_o = oe_n_i ? ~old_q : {mem[ev], mem[ev + 8'h01]};
  // ========================================
  // Storage
  always_ff @(posedge clk_i)
  begin
    old_q <= d_o;
    cnt_q <= (busy_n_i || hit) ? 4'h0 : cnt_q + 4'h1;
    if (hit && !fail_i && !rw_i && !lane_n_i[1])
      mem[ev] <= d_i[15:8];
    if (hit && !fail_i && !rw_i && !lane_n_i[0])
      mem[ev + 8'h01] <= d_i[7:0];
  end
endmodule

// file: bench/test_external_bus_cycle_control.sv
// Self-checking bench of the external bus cycle controller
`timescale 1ns/100ps
`include "ebc_consts.svh"
module test_external_bus_cycle_control;
  import ebc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  ebc_req_s req = '0;
  ebc_rsp_s rsp;
  logic [7:0][1:0] widths = {2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
  logic sd_mode = 1'b0;
  logic [1:0] strap = `EBC_SZ_BYTE;
  logic [3:0] wt = 4'h0;
  logic fail = 1'b0;
  logic ready, dout_en, oe_n, rw, ack_n, err_n, start_n, busy_n, size_oe, lane_seen, s_rw, s_oe;
  logic [23:0] addr, s_addr;
  logic [15:0] din, dout;
  logic [1:0] lanes, size_out, sdsel_n, s_lanes, s_sdsel;
  logic [7:0] sel_n, s_sel;
  int miscompares = 0;
  int n_tests = 0;
  int beats, busy_cyc;
  int cycles = 0;
  ebc_ctrl dut_u (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .REQ_VALID_I(valid), .REQ_I(req),
    .REQ_READY_O(ready), .RSP_O(rsp), .CS_WIDTH_I(widths), .SDRAM_MODE_I(sd_mode), .A_O(addr),
    .D_I(din), .D_O(dout), .D_OE_O(dout_en), .BS_O(lanes), .OE_N_O(oe_n), .RW_O(rw),
    .TA_N_I(ack_n), .TEA_N_I(err_n), .TSIZ_I(strap), .TSIZ_O(size_out), .TSIZ_OE_O(size_oe),
    .TS_N_O(start_n), .TIP_N_O(busy_n), .CS_N_O(sel_n), .SDCS_N_O(sdsel_n));
  ebc_mem_model mem_u (.clk_i(clk), .a_i(addr), .d_i(dout), .lane_n_i(lanes), .oe_n_i(oe_n),
    .rw_i(rw), .busy_n_i(busy_n), .wait_i(wt), .fail_i(fail), .d_o(din), .ack_n_o(ack_n),
    .err_n_o(err_n));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // ========================================
  // Monitor and timeout
  always @(posedge clk)
  begin
    cycles++;
    if (!start_n)
    begin
      beats++;
      s_sel = sel_n;
      s_sdsel = sdsel_n;
      s_lanes = lanes;
      s_rw = rw;
      s_oe = oe_n;
      s_addr = addr;
    end
    if (!busy_n)
      busy_cyc++;
    if (lanes !== 2'b11 && !sd_mode)
      lane_seen = 1'b1;
    // Run needs well under a hundred cycles
    if (cycles == 2000)
    begin
      miscompares++;
      stop_test();
    end
  end
  // ========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic go(input logic wr, input logic [1:0] sz, tg, input logic [2:0] c, input logic [31:0] ad, wd);
    int k;
    beats = 0;
    busy_cyc = 0;
    lane_seen = 1'b0;
    req = '{addr: ad, wdata: wd, write: wr, size: sz, target: tg, cs: c};
    valid = 1'b1;
    @(posedge clk);
    #1 valid = 1'b0;
    for (k = 0; k < 40 && rsp.done !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    chk(rsp.done, 1'b1);
  endtask
  // ========================================
  // Scenarios
  task automatic t_idle();
    chk({ready, start_n, busy_n, oe_n, rw, lanes, dout_en}, 8'hfe);
    chk(sel_n, 8'hff);
    chk(size_oe, 1'b1);
  endtask
  task automatic t_boot();
    go(0, `EBC_SZ_LONG, `EBC_TGT_EXT, 0, 32'h40, 0);
    chk(beats, 4);
    chk(s_addr, 24'h43);
    chk(s_sel, 8'hfe);
  endtask
  task automatic t_rw16();
    go(1, `EBC_SZ_LONG, `EBC_TGT_EXT, 1, 32'h10, 32'h11223344);
    chk(beats, 2);
    chk({s_rw, s_oe, s_addr}, {2'b01, 24'h12});
    go(1, `EBC_SZ_BYTE, `EBC_TGT_EXT, 1, 32'h13, 32'haa);
    chk(s_lanes, 2'b10);
    chk(size_out, `EBC_SZ_BYTE);
    go(1, `EBC_SZ_BYTE, `EBC_TGT_EXT, 1, 32'h10, 32'h55);
    chk(s_lanes, 2'b01);
    go(0, `EBC_SZ_LONG, `EBC_TGT_EXT, 1, 32'h10, 0);
    chk({s_rw, s_oe, s_lanes}, 4'b1000);
    chk(rsp.rdata, 32'h552233aa);
  endtask
  task automatic t_wait();
    wt = 4'h3;
    go(0, `EBC_SZ_WORD, `EBC_TGT_EXT, 1, 32'h10, 0);
    wt = 4'h0;
    chk(busy_cyc, 4);
    chk(beats, 1);
    chk(busy_n, 1'b1);
    chk(rsp.rdata, 32'h5522);
  endtask
  task automatic t_err();
    fail = 1'b1;
    go(0, `EBC_SZ_LONG, `EBC_TGT_EXT, 1, 32'h10, 0);
    fail = 1'b0;
    chk(rsp.err, 1'b1);
    chk(beats, 1);
  endtask
  task automatic t_onchip();
    go(0, `EBC_SZ_WORD, `EBC_TGT_ONCHIP, 1, 32'h10, 0);
    chk(lane_seen, 1'b0);
    chk(rsp.rdata, 32'h0);
    chk(beats, 0);
    go(0, `EBC_SZ_WORD, `EBC_TGT_PERIPH, 1, 32'h10, 0);
    chk(lane_seen, 1'b1);
  endtask
  task automatic t_sdram();
    sd_mode = 1'b1;
    go(0, `EBC_SZ_WORD, `EBC_TGT_SDRAM, 3, 32'h10, 0);
    chk({s_sdsel, s_sel}, {2'b01, 8'hff});
    chk({s_rw, s_lanes}, 3'b111);
    go(0, `EBC_SZ_WORD, `EBC_TGT_EXT, 2, 32'h10, 0);
    sd_mode = 1'b0;
    chk(s_sel, 8'hff);
  endtask
  task automatic t_narrow();
    go(1, `EBC_SZ_WORD, `EBC_TGT_EXT, 2, 32'h20, 32'h1234);
    chk(beats, 2);
    chk(s_addr, 24'h21);
  endtask
  // ========================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    // Strap is only sampled in reset
    strap = `EBC_SZ_WORD;
    @(posedge clk);
    #1;
    t_idle();
    t_boot();
    t_rw16();
    t_wait();
    t_err();
    t_onchip();
    t_sdram();
    t_narrow();
    stop_test();
  end
endmodule
